// File: src/prw_pkg.sv
// Purpose: shared constants for the power reset status and wake gating block
// Assumes: single 25 MHz clock, synchronous active-high reset
// Notes: status bit positions follow the power reset status layout
package prw_pkg;
  // -----------------------------------------------------------------
  // status register layout
  // -----------------------------------------------------------------
  localparam int STAT_WIDTH = 8;
  localparam int BIT_SYS_RESET = 6;
  localparam int BIT_TEST_RESET_PIN = 7;
  localparam logic [7:0] STAT_RESET_VALUE = 8'h00;
  // -----------------------------------------------------------------
  // wake-only group
  // -----------------------------------------------------------------
  localparam int WAKE_GROUP_WIDTH = 32;
  localparam int WAKE_SRC_ESPI = 9;
  // -----------------------------------------------------------------
  // clock figures
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_CLK_MHZ = 0;
  // wake controller states, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_ESPI_WAKE = 4'h4,
    ST_CPU_WAKE = 4'h8
  } prw_state_type;
endpackage : prw_pkg

// File: src/prw_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: destination domain clk
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module prw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  // next values of both stages
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule : prw_sync

// File: src/prw_wake_gate.sv
// Purpose: reset status bits and wake-only clock gating
// Assumes: pins arrive async and are synchronised here
// Notes: gate enables are levels for external clock gate cells
//
// Behaviour
// - bit 7 returns live test-port reset pin
// - pin bit tracks even during boundary scan
// - wake-only event clocks its block, not CPU
// - sleeping chip, chip-select fall clocks eSPI only
// - cycle ends without interrupt, back to sleep
// - eSPI interrupt enabled keeps clocks, CPU runs
// - eSPI reset alone never wakes the chip
// - system reset sets sticky bit 6
// - controller clock fully off in light sleep
`timescale 1ns/10ps
module prw_wake_gate #(
  parameter int WAKE_WIDTH = prw_pkg::WAKE_GROUP_WIDTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic testResetPin,
  input wire logic boundaryScanEn,
  input wire logic system_wide_reset,
  input wire logic sysFlagClearWr,
  input wire logic lightSleepReq,
  input wire logic espiCsPin_n,
  input wire logic espiCycleDone,
  input wire logic espiIrq,
  input wire logic espiIrqEn,
  input wire logic cpuSleepReq,
  input wire logic [WAKE_WIDTH-1:0] wakeEvents,
  input wire logic [WAKE_WIDTH-1:0] wakeEnables,
  output logic [7:0] resetStatus,
  output logic sys_reset_sticky_flag,
  output logic controllerClkEn,
  output logic espiClkEn,
  output logic [WAKE_WIDTH-1:0] blockClkEn,
  output logic cpuIrq,
  output logic asleep
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (WAKE_WIDTH <= prw_pkg::WAKE_SRC_ESPI) begin : g_bad_width
    $error("wake group too narrow for the eSPI source");
  end

  // wake group member test, used by the ST_SLEEP wake term
  function automatic logic srcHit(input logic [WAKE_WIDTH-1:0] v,
                                  input int idx);
    srcHit = v[idx];
  endfunction : srcHit

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pinSync;
  // select enters inverted so the cleared stages read as an idle select,
  // otherwise a false falling edge would follow every reset
  prw_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({testResetPin, ~espiCsPin_n, system_wide_reset}),
    .dout(pinSync)
  );
  logic pinLevel;
  logic csSync_n;
  logic sysRstSync;
  assign pinLevel = pinSync[2];
  assign csSync_n = ~pinSync[1];
  assign sysRstSync = pinSync[0];

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  logic pinLevel_ff;
  logic nxt_pinLevel;
  logic sysFlag_ff;
  logic nxt_sysFlag;

  // scan enable is deliberately ignored, pin always visible
  always_comb begin
    nxt_pinLevel = pinLevel;
    nxt_sysFlag = sysFlag_ff;
    if (sysFlagClearWr) begin
      nxt_sysFlag = 1'b0;
    end
    if (sysRstSync) begin
      nxt_sysFlag = 1'b1; // set beats clear
    end
  end

  // flag survives block reset so software can see what happened
  always_ff @(posedge clk) begin
    if (reset) begin
      pinLevel_ff <= 1'b0;
    end else begin
      pinLevel_ff <= nxt_pinLevel;
    end
    sysFlag_ff <= nxt_sysFlag;
  end

  // byte view of the status register
  always_comb begin
    resetStatus = prw_pkg::STAT_RESET_VALUE;
    resetStatus[prw_pkg::BIT_TEST_RESET_PIN] = pinLevel_ff;
    resetStatus[prw_pkg::BIT_SYS_RESET] = sysFlag_ff;
  end
  assign sys_reset_sticky_flag = sysFlag_ff;

  // ---------------------------------------------------------------
  // chip-select edge detect on the synchronised level
  // ---------------------------------------------------------------
  logic csPrev_ff;
  logic nxt_csPrev;
  logic csFall;
  always_comb begin
    nxt_csPrev = csSync_n;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      csPrev_ff <= 1'b1;
    end else begin
      csPrev_ff <= nxt_csPrev;
    end
  end
  assign csFall = csPrev_ff & ~csSync_n;

  // ---------------------------------------------------------------
  // wake state machine
  // ---------------------------------------------------------------
  prw_pkg::prw_state_type state_ff;
  prw_pkg::prw_state_type nxt_state;
  logic [WAKE_WIDTH-1:0] blkEn_ff;
  logic [WAKE_WIDTH-1:0] nxt_blkEn;
  logic [WAKE_WIDTH-1:0] liveWake;
  logic espiIrqLive;

  // eSPI reset is not in this path; only enabled group bits wake
  assign liveWake = wakeEvents & wakeEnables;
  assign espiIrqLive = espiIrq & espiIrqEn;

  always_comb begin
    nxt_state = state_ff;
    nxt_blkEn = blkEn_ff;
    case (state_ff)
      prw_pkg::ST_RUN: begin
        nxt_blkEn = '1;
        if (lightSleepReq) begin
          nxt_state = prw_pkg::ST_SLEEP;
          nxt_blkEn = '0;
        end
      end
      prw_pkg::ST_SLEEP: begin
        // only the source block is clocked, CPU stays off
        nxt_blkEn = liveWake;
        if (csFall || srcHit(liveWake, prw_pkg::WAKE_SRC_ESPI)) begin
          nxt_state = prw_pkg::ST_ESPI_WAKE;
        end
      end
      prw_pkg::ST_ESPI_WAKE: begin
        nxt_blkEn = liveWake;
        if (espiIrqLive) begin
          nxt_state = prw_pkg::ST_CPU_WAKE;
        end else if (espiCycleDone) begin
          nxt_state = prw_pkg::ST_SLEEP;
        end
      end
      prw_pkg::ST_CPU_WAKE: begin
        nxt_blkEn = '1;
        if (cpuSleepReq) begin
          nxt_state = prw_pkg::ST_SLEEP;
          nxt_blkEn = '0;
        end
      end
      default: begin
        nxt_state = prw_pkg::ST_RUN;
        nxt_blkEn = '1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= prw_pkg::ST_RUN;
      blkEn_ff <= '1;
    end else begin
      state_ff <= nxt_state;
      blkEn_ff <= nxt_blkEn;
    end
  end

  // ---------------------------------------------------------------
  // gate outputs
  // ---------------------------------------------------------------
  // core clock held at 0 MHz whenever asleep
  assign controllerClkEn = (state_ff == prw_pkg::ST_RUN) ||
                           (state_ff == prw_pkg::ST_CPU_WAKE);
  assign espiClkEn = (state_ff != prw_pkg::ST_SLEEP);
  assign blockClkEn = blkEn_ff;
  assign cpuIrq = espiIrqLive & (state_ff == prw_pkg::ST_CPU_WAKE);
  assign asleep = (state_ff == prw_pkg::ST_SLEEP);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pin_bit_live: assert property (@(posedge clk) disable iff (reset)
    resetStatus[7] == $past(pinLevel))
    else $error("pin bit not tracking pin");
  a_pin_scan_ok: assert property (@(posedge clk) disable iff (reset)
    boundaryScanEn ##1 1'b1 |-> resetStatus[7] == $past(pinLevel))
    else $error("pin bit lost during scan");
  a_cs_wakes_espi: assert property (@(posedge clk) disable iff (reset)
    asleep && csFall |=> espiClkEn && !controllerClkEn)
    else $error("chip-select did not wake eSPI alone");
  a_wake_only_cpu: assert property (@(posedge clk) disable iff (reset)
    state_ff == prw_pkg::ST_ESPI_WAKE |-> !controllerClkEn)
    else $error("cpu clock on during wake-only");
  a_done_to_sleep: assert property (@(posedge clk) disable iff (reset)
    state_ff == prw_pkg::ST_ESPI_WAKE && espiCycleDone && !espiIrqLive
    |=> asleep && !espiClkEn)
    else $error("cycle end did not return to sleep");
  a_irq_keeps_clk: assert property (@(posedge clk) disable iff (reset)
    state_ff == prw_pkg::ST_ESPI_WAKE && espiIrqLive
    |=> controllerClkEn ##0 cpuIrq == espiIrqLive)
    else $error("interrupt did not keep clock on");
  a_no_rst_wake: assert property (@(posedge clk) disable iff (reset)
    asleep && !csFall && liveWake == '0 |=> asleep)
    else $error("woke with no enabled source");
  a_sys_flag_set: assert property (@(posedge clk)
    sysRstSync |=> sys_reset_sticky_flag)
    else $error("system reset did not set flag");
  a_set_beats_clr: assert property (@(posedge clk)
    sysRstSync && sysFlagClearWr |=> resetStatus[6])
    else $error("clear beat set");
  a_clr_works: assert property (@(posedge clk)
    !sysRstSync && sysFlagClearWr |=> !sys_reset_sticky_flag)
    else $error("flag not cleared");
  a_sleep_core_off: assert property (@(posedge clk) disable iff (reset)
    asleep |-> !controllerClkEn)
    else $error("core clock on in sleep");

  c_espi_short: cover property (@(posedge clk) disable iff (reset)
    asleep ##1 state_ff == prw_pkg::ST_ESPI_WAKE ##[1:20] asleep);
  c_espi_irq: cover property (@(posedge clk) disable iff (reset)
    state_ff == prw_pkg::ST_ESPI_WAKE ##1 state_ff == prw_pkg::ST_CPU_WAKE);
  c_set_clear: cover property (@(posedge clk)
    sysRstSync && sysFlagClearWr);
endmodule : prw_wake_gate

// File: tb/prw_espi_host.sv
// Purpose: stand-in for the eSPI host and the on-chip processor
// Assumes: signals change 1 ns after a rising edge
// Notes: cycle is two edges longer with irq; irq is held until the cycle ends
`timescale 1ns/10ps
module prw_espi_host (
  input wire logic clk,
  input wire logic cpuIrq,
  output logic espiCsPin_n,
  output logic espiCycleDone,
  output logic espiIrq,
  output logic cpuSleepReq
);
  // idle bus: select pulled high, no events
  initial begin
    espiCsPin_n = 1'b1;
    espiCycleDone = 1'b0;
    espiIrq = 1'b0;
    cpuSleepReq = 1'b0;
  end
  task automatic edge_after(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : edge_after
  // one bus cycle; irq models a downstream wire or packet
  task automatic run_cycle(input logic irq);
    edge_after(1);
    espiCsPin_n = 1'b0;
    edge_after(6);
    espiIrq = irq;
    if (irq) begin
      edge_after(2); // processor must be awake before the end
    end
    espiCycleDone = 1'b1;
    edge_after(1);
    espiCycleDone = 1'b0;
    espiCsPin_n = 1'b1;
    if (irq && cpuIrq) begin
      cpuSleepReq = 1'b1; // serviced, back to sleep
    end
    espiIrq = 1'b0;
    edge_after(1);
    cpuSleepReq = 1'b0;
  endtask : run_cycle
endmodule : prw_espi_host

// File: tb/power_reset_status_wake_gating_test.sv
// Purpose: self-checking bench for reset status and wake gating
// Assumes: inputs change 1 ns after rising edges
// Notes: pin bits lag three edges behind their pins
`timescale 1ns/10ps
module power_reset_status_wake_gating_test;
  logic clk, reset, testResetPin, boundaryScanEn, sysWideReset;
  logic sysFlagClearWr, lightSleepReq, espiIrqEn, stickyFlag;
  logic controllerClkEn, espiClkEn, cpuIrq, asleep;
  logic espiCsPin_n, espiCycleDone, espiIrq, cpuSleepReq;
  logic [7:0] resetStatus;
  logic [31:0] wakeEvents, wakeEnables, blockClkEn;
  int failures, testsRun;
  // rows: pin level, boundary scan, expected status bit
  logic [2:0] rows [4] = '{3'b000, 3'b101, 3'b010, 3'b111};
  always #20 clk = ~clk;
  prw_wake_gate DUT (.clk(clk), .reset(reset),
    .testResetPin(testResetPin), .boundaryScanEn(boundaryScanEn),
    .system_wide_reset(sysWideReset), .sysFlagClearWr(sysFlagClearWr),
    .lightSleepReq(lightSleepReq), .espiCsPin_n(espiCsPin_n),
    .espiCycleDone(espiCycleDone), .espiIrq(espiIrq),
    .espiIrqEn(espiIrqEn), .cpuSleepReq(cpuSleepReq),
    .wakeEvents(wakeEvents), .wakeEnables(wakeEnables),
    .resetStatus(resetStatus), .sys_reset_sticky_flag(stickyFlag),
    .controllerClkEn(controllerClkEn), .espiClkEn(espiClkEn),
    .blockClkEn(blockClkEn), .cpuIrq(cpuIrq), .asleep(asleep));
  prw_espi_host host (.clk(clk), .cpuIrq(cpuIrq),
    .espiCsPin_n(espiCsPin_n), .espiCycleDone(espiCycleDone),
    .espiIrq(espiIrq), .cpuSleepReq(cpuSleepReq));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk_bit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic finish_test();
    $display("checks %0d failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // watchdog: whole run needs about 80 cycles
  initial begin
    #(1000 * 40);
    failures++;
    $display("watchdog expired");
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {testResetPin, boundaryScanEn, sysWideReset} = 3'b000;
    {sysFlagClearWr, lightSleepReq, espiIrqEn} = 3'b001;
    wakeEvents = 32'h0;
    wakeEnables = 32'h208; // eSPI wakes on source 9
    failures = 0;
    testsRun = 0;
    step(8);
    reset = 1'b0;
    step(1);
    chk_bit(controllerClkEn, 1'b1);
    chk_vec(blockClkEn, 32'hffffffff);
    $display("reset test ended");
    foreach (rows[i]) begin
      {testResetPin, boundaryScanEn} = rows[i][2:1];
      step(4);
      chk_bit(resetStatus[7], rows[i][0]);
    end
    $display("pin status test ended");
    sysWideReset = 1'b1;
    step(4);
    chk_bit(resetStatus[6], 1'b1);
    sysFlagClearWr = 1'b1; // clear while reset still high
    step(1);
    chk_bit(stickyFlag, 1'b1);
    sysFlagClearWr = 1'b0;
    step(1);
    chk_bit(stickyFlag, 1'b1);
    sysWideReset = 1'b0;
    step(4);
    sysFlagClearWr = 1'b1;
    step(1);
    sysFlagClearWr = 1'b0;
    step(1);
    chk_bit(stickyFlag, 1'b0);
    chk_vec({24'h0, resetStatus}, 32'h80);
    $display("sticky flag test ended");
    lightSleepReq = 1'b1;
    step(1);
    lightSleepReq = 1'b0;
    step(1);
    chk_bit(controllerClkEn, 1'b0);
    wakeEvents = 32'h28; // bit 5 is not enabled
    step(2);
    chk_vec(blockClkEn, 32'h8);
    chk_bit(controllerClkEn, 1'b0);
    wakeEvents = 32'h0;
    step(3);
    chk_bit(asleep, 1'b1);
    // group source 9 alone wakes the eSPI block, processor stays off
    wakeEvents = 32'h200;
    step(1);
    chk_bit(espiClkEn, 1'b1);
    chk_bit(controllerClkEn, 1'b0);
    chk_vec(blockClkEn, 32'h200);
    wakeEvents = 32'h0;
    host.run_cycle(1'b0);
    chk_bit(asleep, 1'b1);
    step(3);
    $display("wake-only test ended");
    fork
      host.run_cycle(1'b0);
      begin
        step(6);
        chk_bit(espiClkEn, 1'b1);
        chk_bit(controllerClkEn, 1'b0);
      end
    join
    chk_bit(asleep, 1'b1);
    chk_bit(espiClkEn, 1'b0);
    step(3);
    fork
      host.run_cycle(1'b1);
      begin
        step(9);
        chk_bit(cpuIrq, 1'b1);
        chk_bit(controllerClkEn, 1'b1);
      end
    join
    chk_bit(asleep, 1'b1);
    $display("eSPI wake test ended");
    finish_test();
  end
endmodule : power_reset_status_wake_gating_test
